/* logic/gsbt_pkg.sv */
/*
  Constants and types for the gated sixteen bit timer: register indices,
  field positions, reset values and the control word layout.
  Assumes nothing beyond a SystemVerilog compiler; no timescale here.
*/
package gsbt_pkg;

  // ==========================================================
  // Register bus shape
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ==========================================================
  // Register indices
  localparam logic [2:0] REG_COUNT_LOW  = 3'h0;
  localparam logic [2:0] REG_COUNT_HIGH = 3'h1;
  localparam logic [2:0] REG_CONTROL    = 3'h2;
  localparam logic [2:0] REG_CONFIG     = 3'h3;
  localparam logic [2:0] REG_STATUS     = 3'h4;
  localparam logic [2:0] REG_PINS       = 3'h5;

  // ==========================================================
  // Field positions
  localparam int CFG_ALT_BIT      = 0;
  localparam int STS_OVF_BIT      = 0;
  localparam int STS_TBASE_BIT    = 1;
  localparam int STS_XTAL_BIT     = 2;
  localparam int PIN_DIR_A_BIT    = 0;
  localparam int PIN_DIR_B_BIT    = 1;
  localparam int PIN_DATA_A_BIT   = 4;
  localparam int PIN_DATA_B_BIT   = 5;

  // ==========================================================
  // Reset values
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  PIN_DIR_RESET = 2'h3;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

  // ==========================================================
  // Timing: instruction cycle is four oscillator cycles
  localparam int          INSTR_DIV     = 4;
  localparam logic [1:0]  INSTR_LAST    = 2'(INSTR_DIV - 1);

  // ==========================================================
  // Prescale encodings
  typedef enum logic [1:0] {
    GSBT_PRE_1 = 2'h0,
    GSBT_PRE_2 = 2'h1,
    GSBT_PRE_4 = 2'h2,
    GSBT_PRE_8 = 2'h3
  } gsbt_prescale_t;

  // ==========================================================
  // Control word, most significant field first
  typedef struct packed {
    logic           gate_invert;
    logic           gate_enable;
    gsbt_prescale_t prescale_select;
    logic           crystal_osc_enable;
    logic           sync_disable;
    logic           count_source_select;
    logic           timer_on;
  } gsbt_ctrl_t;

endpackage

/* logic/gsbt_prescaler.sv */
/*
  Prescaler of the gated sixteen bit timer: divides input pulses by
  1, 2, 4 or 8. Assumes single-cycle input pulses on the system clock
  and a synchronous clear that wins over counting.
*/
`timescale 1ns/10ps

module gsbt_prescaler #(
  parameter int CNT_W = 3
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Control
  input  wire gsbt_pkg::gsbt_prescale_t ratio,
  input  wire logic                    clear,
  // Pulses
  input  wire logic                    pulse_in,
  output      logic                    pulse_out
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] mask;

  // ==========================================================
  // Ratio decode
  always_comb begin
    unique case (ratio)
      gsbt_pkg::GSBT_PRE_1: mask = CNT_W'(0);
      gsbt_pkg::GSBT_PRE_2: mask = CNT_W'(1);
      gsbt_pkg::GSBT_PRE_4: mask = CNT_W'(3);
      gsbt_pkg::GSBT_PRE_8: mask = CNT_W'(7);
    endcase
  end

  // Output fires on the pulse that completes a full division
  assign pulse_out = pulse_in && !clear && ((count & mask) == mask);

  // ==========================================================
  // Counter, hidden from software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (pulse_in) begin
      count <= count + CNT_W'(1);
    end
  end

endmodule

/* logic/gsbt_timer.sv */
/*
  Top of the gated sixteen bit timer: register port, clock source
  selection, external input edge logic, gating, count and overflow.
  Assumes MCLK is the full oscillator clock, all inputs are synchronous
  to it, and MCLK keeps running in Sleep for the asynchronous path.
*/
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - 16-bit up count, byte writes replace directly
// - Source from select and alternate bits
// - Internal clock advances per prescaler pulse
// - External input counts on rising edges
// - External input synchronised or asynchronous by choice
// - First rising edge needs prior falling edge
// - Prescale divide by 1, 2, 4 or 8
// - Prescaler hidden, cleared on count writes
// - Crystal enable bit runs oscillator, also in Sleep
// - Crystal usable only with suitable primary clock
// - Crystal forces pins input, reads dir 1, data 0
// - Sync disable bypasses synchroniser for external source
// - Asynchronous mode counts in Sleep, overflow wakes
// - No time base when asynchronous or full-rate clock
// - Crystal serves as external clock when allowed
// - Counts only while timer on, else holds
// - Prescale codes 00,01,10,11 give 1,2,4,8
// - Rollover to zero sets overflow flag, software clears
// - Gate enable counts only during active gate level

module gsbt_timer (
  // Clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RESET_N,
  // Register port
  input  wire logic [gsbt_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [gsbt_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                        REG_WRITE,
  input  wire logic                        REG_READ,
  output      logic [gsbt_pkg::DATA_W-1:0] REG_RDATA,
  // System state
  input  wire logic                        SLEEP,
  input  wire logic                        PRIMARY_CLK_OK,
  // Count inputs
  input  wire logic                        EXTERNAL_COUNT_INPUT,
  input  wire logic                        CRYSTAL_CLK,
  input  wire logic                        GATE,
  // Oscillator pin data as seen on the port
  input  wire logic                        OSC_PIN_A_DATA,
  input  wire logic                        OSC_PIN_B_DATA,
  // Pin direction, high means input
  output      logic                        OSC_PIN_A_DIRECTION,
  output      logic                        OSC_PIN_B_DIRECTION,
  // Oscillator and capture unit
  output      logic                        CRYSTAL_OSC_RUN,
  output      logic [15:0]                 TIME_BASE,
  output      logic                        TIME_BASE_VALID,
  // Events
  output      logic                        OVERFLOW_FLAG,
  output      logic                        WAKE
);

  // ==========================================================
  // Control state
  gsbt_pkg::gsbt_ctrl_t ctrl;
  logic                 alternate_clock_select;
  logic [1:0]           pin_dir;
  logic [15:0]          count;
  logic                 overflow_flag;

  // ==========================================================
  // Derived selections
  logic crystal_active;
  logic ext_level;
  logic async_mode;
  logic counter_mode;
  logic write_low;
  logic write_high;
  logic write_count;
  logic write_status;

  assign write_low    = REG_WRITE && (REG_ADDR == gsbt_pkg::REG_COUNT_LOW);
  assign write_high   = REG_WRITE && (REG_ADDR == gsbt_pkg::REG_COUNT_HIGH);
  assign write_count  = write_low || write_high;
  assign write_status = REG_WRITE && (REG_ADDR == gsbt_pkg::REG_STATUS);

  // Shared oscillator only runs with a compatible primary clock
  assign crystal_active = ctrl.crystal_osc_enable && PRIMARY_CLK_OK;
  assign CRYSTAL_OSC_RUN = crystal_active;

  // Crystal takes the place of the pin when it runs
  assign ext_level = crystal_active ? CRYSTAL_CLK
                                    : EXTERNAL_COUNT_INPUT;
  assign counter_mode = ctrl.count_source_select;
  assign async_mode   = counter_mode && ctrl.sync_disable;

  // ==========================================================
  // Synchronised path; first stage feeds only the second
  logic sync_1;
  logic sync_2;
  logic sync_prev;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_1    <= 1'b0;
      sync_2    <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_1    <= ext_level;
      sync_2    <= sync_1;
      sync_prev <= sync_2;
    end
  end

  // ==========================================================
  // Asynchronous path: one sample, no synchroniser latency
  logic async_prev;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      async_prev <= 1'b0;
    end else begin
      async_prev <= ext_level;
    end
  end

  // ==========================================================
  // Edge selection and falling-edge arming
  logic ext_now;
  logic ext_prev;
  logic armed;
  logic ext_rise;

  assign ext_now  = async_mode ? ext_level  : sync_2;
  assign ext_prev = async_mode ? async_prev : sync_prev;

  // Reset state of the edge registers is low, so arming on a seen
  // low level avoids counting an input that starts out high
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      armed <= 1'b0;
    end else if (!counter_mode) begin
      armed <= 1'b0;
    end else if (!ext_now) begin
      armed <= 1'b1;
    end
  end

  assign ext_rise = armed && ext_now && !ext_prev;

  // ==========================================================
  // Instruction cycle divider
  logic [1:0] instr_phase;
  logic       instr_tick;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  assign instr_tick = (instr_phase == gsbt_pkg::INSTR_LAST);

  // ==========================================================
  // Source select, gate and run conditions
  logic source_tick;
  logic gate_ok;
  logic run;
  logic pre_in;
  logic pre_out;

  always_comb begin
    if (counter_mode) begin
      source_tick = ext_rise;
    end else if (alternate_clock_select) begin
      source_tick = 1'b1;
    end else begin
      source_tick = instr_tick;
    end
  end

  // Gate invert set means active high
  assign gate_ok = !ctrl.gate_enable
                || (GATE == ctrl.gate_invert);

  // Only the asynchronous counter keeps going in Sleep
  assign run = ctrl.timer_on && gate_ok
            && (!SLEEP || async_mode);

  assign pre_in = source_tick && run;

  gsbt_prescaler #(
    .CNT_W (3)
  ) gsbt_prescaler_inst (
    .clk       (MCLK),
    .reset_n   (RESET_N),
    .ratio     (ctrl.prescale_select),
    .clear     (write_count),
    .pulse_in  (pre_in),
    .pulse_out (pre_out)
  );

  // ==========================================================
  // Count register; a software write wins over an increment
  logic overflow_event;

  assign overflow_event = pre_out && (count == gsbt_pkg::COUNT_MAX);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count <= gsbt_pkg::COUNT_RESET;
    end else if (write_low) begin
      count <= {count[15:8], REG_WDATA};
    end else if (write_high) begin
      count <= {REG_WDATA, count[7:0]};
    end else if (pre_out) begin
      count <= count + 16'h0001;
    end
  end

  // ==========================================================
  // Overflow flag: set beats a simultaneous software clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      overflow_flag <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1;
    end else if (write_status && !REG_WDATA[gsbt_pkg::STS_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  // Wake pulse for overflow seen while asleep
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= overflow_event && SLEEP;
    end
  end

  assign OVERFLOW_FLAG = overflow_flag;

  // ==========================================================
  // Control registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= gsbt_pkg::CONTROL_RESET;
    end else if (REG_WRITE && (REG_ADDR == gsbt_pkg::REG_CONTROL)) begin
      ctrl <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alternate_clock_select <= 1'b0;
    end else if (REG_WRITE && (REG_ADDR == gsbt_pkg::REG_CONFIG)) begin
      alternate_clock_select <= REG_WDATA[gsbt_pkg::CFG_ALT_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_dir <= gsbt_pkg::PIN_DIR_RESET;
    end else if (REG_WRITE && (REG_ADDR == gsbt_pkg::REG_PINS)) begin
      pin_dir <= {REG_WDATA[gsbt_pkg::PIN_DIR_B_BIT],
                  REG_WDATA[gsbt_pkg::PIN_DIR_A_BIT]};
    end
  end

  // ==========================================================
  // Pin overrides while the crystal owns the pins
  assign OSC_PIN_A_DIRECTION = pin_dir[0] || crystal_active;
  assign OSC_PIN_B_DIRECTION = pin_dir[1] || crystal_active;

  // ==========================================================
  // Time base for the capture unit
  assign TIME_BASE       = count;
  assign TIME_BASE_VALID = !async_mode
                        && !(!counter_mode && alternate_clock_select);

  // ==========================================================
  // Read data, one cycle after the strobe, zero otherwise
  logic [7:0] next_rdata;
  logic [7:0] pins_view;

  always_comb begin
    pins_view = 8'h00;
    pins_view[gsbt_pkg::PIN_DIR_A_BIT]  = OSC_PIN_A_DIRECTION;
    pins_view[gsbt_pkg::PIN_DIR_B_BIT]  = OSC_PIN_B_DIRECTION;
    pins_view[gsbt_pkg::PIN_DATA_A_BIT] = OSC_PIN_A_DATA && !crystal_active;
    pins_view[gsbt_pkg::PIN_DATA_B_BIT] = OSC_PIN_B_DATA && !crystal_active;
  end

  always_comb begin
    next_rdata = 8'h00;
    if (REG_READ) begin
      unique case (REG_ADDR)
        gsbt_pkg::REG_COUNT_LOW:  next_rdata = count[7:0];
        gsbt_pkg::REG_COUNT_HIGH: next_rdata = count[15:8];
        gsbt_pkg::REG_CONTROL:    next_rdata = ctrl;
        gsbt_pkg::REG_CONFIG: begin
          next_rdata[gsbt_pkg::CFG_ALT_BIT] = alternate_clock_select;
        end
        gsbt_pkg::REG_STATUS: begin
          next_rdata[gsbt_pkg::STS_OVF_BIT]   = overflow_flag;
          next_rdata[gsbt_pkg::STS_TBASE_BIT] = TIME_BASE_VALID;
          next_rdata[gsbt_pkg::STS_XTAL_BIT]  = crystal_active;
        end
        gsbt_pkg::REG_PINS:       next_rdata = pins_view;
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule

/* sim/gsbt_ext_source.sv */
/*
  Far side: a count source on the input pin and the crystal.
  Assumes levels may change just after MCLK rises.
*/
`timescale 1ns/10ps

module gsbt_ext_source #(
  parameter int HALF = 5
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Enables
  input  wire logic pin_enable,
  input  wire logic crystal_run,
  // Levels
  output      logic pin,
  output      logic crystal
);
  logic [7:0] cnt;
  logic       level;

  // ==========================================================
  // Toggle; stands still and low while unused
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt   <= 8'h00;
      level <= 1'b0;
    end else if (!(pin_enable || crystal_run)) begin
      cnt   <= 8'h00;
      level <= 1'b0;
    end else if (cnt == 8'(HALF - 1)) begin
      cnt   <= 8'h00;
      level <= ~level;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign pin     = pin_enable && level;
  assign crystal = crystal_run && level;
endmodule

/* sim/gsbt_timer_monitor.sv */
/*
  Checker of the gated sixteen bit timer, on the top ports only.
  Assumes one domain: MCLK with the asynchronous low reset RESET_N.
*/
`timescale 1ns/10ps

module gsbt_timer_monitor (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RESET_N,
  // Register port
  input wire logic [2:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WRITE,
  input wire logic        REG_READ,
  input wire logic [7:0]  REG_RDATA,
  // System and pins
  input wire logic        SLEEP,
  input wire logic        PRIMARY_CLK_OK,
  input wire logic        OSC_PIN_A_DIRECTION,
  input wire logic        OSC_PIN_B_DIRECTION,
  input wire logic        CRYSTAL_OSC_RUN,
  // Count and events
  input wire logic [15:0] TIME_BASE,
  input wire logic        OVERFLOW_FLAG,
  input wire logic        WAKE
);
  logic cw;

  // ==========================================================
  // Checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  assign cw = REG_WRITE && REG_ADDR <= gsbt_pkg::REG_COUNT_HIGH;

  chk_rdata_idle: assert property (
    !$past(REG_READ) |-> REG_RDATA == 8'h00) else $error("read data stuck");
  chk_write_low: assert property (
    REG_WRITE && REG_ADDR == gsbt_pkg::REG_COUNT_LOW
    |=> TIME_BASE[7:0] == $past(REG_WDATA)) else $error("low write lost");
  chk_read_high: assert property (
    REG_READ && REG_ADDR == gsbt_pkg::REG_COUNT_HIGH
    |=> REG_RDATA == $past(TIME_BASE[15:8])) else $error("bad high read");
  chk_count_step: assert property (
    !$past(cw) |-> 16'(TIME_BASE - $past(TIME_BASE)) <= 16'h0001)
    else $error("count jumped");
  chk_overflow_set: assert property (
    $past(TIME_BASE) == 16'hFFFF && TIME_BASE == 16'h0000 && !$past(cw)
    |-> OVERFLOW_FLAG) else $error("rollover without flag");
  chk_flag_cause: assert property (
    $rose(OVERFLOW_FLAG) |-> $past(TIME_BASE) == 16'hFFFF)
    else $error("flag without rollover");
  chk_flag_clear: assert property (
    $fell(OVERFLOW_FLAG) |-> $past(REG_WRITE) && $past(REG_WDATA[0]) == 1'b0
    && $past(REG_ADDR) == gsbt_pkg::REG_STATUS) else $error("flag lost");
  chk_crystal_dirs: assert property (
    CRYSTAL_OSC_RUN |-> OSC_PIN_A_DIRECTION && OSC_PIN_B_DIRECTION)
    else $error("crystal pins driven");
  chk_crystal_gate: assert property (
    CRYSTAL_OSC_RUN |-> PRIMARY_CLK_OK) else $error("crystal not allowed");
  chk_wake_pulse: assert property (
    WAKE |-> SLEEP && OVERFLOW_FLAG ##1 !WAKE) else $error("bad wake");
endmodule

bind gsbt_timer gsbt_timer_monitor gsbt_timer_monitor_inst (
  .MCLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ,
  .REG_RDATA, .SLEEP, .PRIMARY_CLK_OK, .OSC_PIN_A_DIRECTION,
  .OSC_PIN_B_DIRECTION, .CRYSTAL_OSC_RUN, .TIME_BASE, .OVERFLOW_FLAG,
  .WAKE
);

/* sim/gsbt_timer_test.sv */
/*
  Self-checking bench of the gated sixteen bit timer.
  Assumes the bound checker and the far-side source model.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
  end \
end

module gsbt_timer_test;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        sleep = 1'b0;
  logic        clk_ok = 1'b0;
  logic        ext_en = 1'b0;
  logic        gate = 1'b0;
  logic        pin_d = 1'b0;
  int          n_wake = 0;
  logic        ext_pin, xtal, dir_a, dir_b, xrun, tbv, ovf, wake;
  logic [7:0]  rdata;
  logic [15:0] tb;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed = 32'h2B5B;

  gsbt_timer gsbt_timer_inst (.MCLK(mclk), .RESET_N(reset_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr_s),
    .REG_READ(rd_s), .REG_RDATA(rdata), .SLEEP(sleep),
    .PRIMARY_CLK_OK(clk_ok), .EXTERNAL_COUNT_INPUT(ext_pin),
    .CRYSTAL_CLK(xtal), .GATE(gate), .OSC_PIN_A_DATA(pin_d),
    .OSC_PIN_B_DATA(pin_d), .OSC_PIN_A_DIRECTION(dir_a),
    .OSC_PIN_B_DIRECTION(dir_b), .CRYSTAL_OSC_RUN(xrun),
    .TIME_BASE(tb), .TIME_BASE_VALID(tbv), .OVERFLOW_FLAG(ovf),
    .WAKE(wake));
  gsbt_ext_source gsbt_ext_source_inst (.clk(mclk), .reset_n(reset_n),
    .pin_enable(ext_en), .crystal_run(xrun), .pin(ext_pin),
    .crystal(xtal));

  // ==========================================================
  // Clock, reset, helpers
  initial forever #20 mclk = ~mclk;
  // Wake pulses are counted here only, so one process owns the count
  always @(posedge mclk) if (wake === 1'b1) n_wake <= n_wake + 1;

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    `CHK(rdata, e)
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Sources are free running, so counts are judged within three
  function automatic logic near(input logic [15:0] g, input logic [15:0] e);
    return 16'(g - e + 16'h0003) <= 16'h0006;
  endfunction
  function automatic logic [15:0] ticks(input int n, input int div);
    return 16'(n / div);
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 4700 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    logic [15:0] v;
    int          div;
    int          w0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(3'h2, 8'h00);
    rd(3'h4, 8'h02);
    rd(3'h5, 8'h03);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'h00);
    $display("test reset done");
    repeat (4) begin
      v = 16'($random(seed));
      wr(3'h0, v[7:0]);
      wr(3'h1, v[15:8]);
      rd(3'h0, v[7:0]);
      rd(3'h1, v[15:8]);
    end
    $display("test bytes done");
    for (int p = 0; p < 8; p++) begin
      div = (p[0] ? 1 : gsbt_pkg::INSTR_DIV) << p[2:1];
      wr(3'h3, {7'h00, p[0]});
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, {2'h0, p[2:1], 4'h1});
      run(256);
      wr(3'h2, 8'h00);
      v = tb;
      `CHK(near(v, ticks(258, div)), 1'b1)
      run(20);
      `CHK(tb, v)
    end
    $display("test prescale done");
    wr(3'h0, 8'hFE);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'h01);
    run(8);
    wr(3'h2, 8'h00);
    rd(3'h4, 8'h01);
    wr(3'h4, 8'hFF);
    `CHK(ovf, 1'b1)
    wr(3'h4, 8'h00);
    `CHK(ovf, 1'b0)
    $display("test overflow done");
    wr(3'h3, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, 8'hF0);
      wr(3'h1, 8'hFF);
      wr(3'h4, 8'h00);
      w0 = n_wake;
      wr(3'h2, m[0] ? 8'h07 : 8'h03);
      `CHK(tbv, ~m[0])
      @(posedge mclk);
      sleep  <= m[1];
      ext_en <= 1'b1;
      run(400);
      @(posedge mclk);
      ext_en <= 1'b0;
      run(10);
      v = 16'hFFF0 + ticks(m == 2 ? 0 : 400, 10);
      `CHK(near(tb, v), 1'b1)
      `CHK(ovf, m != 2)
      `CHK((n_wake != w0), (m == 3))
    end
    @(posedge mclk);
    sleep <= 1'b0;
    $display("test external done");
    wr(3'h3, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      @(posedge mclk);
      gate <= i[0];
      wr(3'h2, i[1] ? 8'hC1 : 8'h41);
      run(50);
      wr(3'h2, 8'h00);
      `CHK(near(tb, ticks(i[1] == i[0] ? 52 : 0, 1)), 1'b1)
    end
    $display("test gate done");
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    @(posedge mclk);
    pin_d <= 1'b1;
    wr(3'h5, 8'h00);
    `CHK({dir_a, dir_b}, 2'h0)
    rd(3'h5, 8'h30);
    wr(3'h2, 8'h08);
    `CHK(xrun, 1'b0)
    rd(3'h5, 8'h30);
    @(posedge mclk);
    clk_ok <= 1'b1;
    run(1);
    `CHK(xrun, 1'b1)
    `CHK({dir_a, dir_b}, 2'h3)
    rd(3'h5, 8'h03);
    rd(3'h4, 8'h06);
    run(20);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h0B);
    run(400);
    wr(3'h2, 8'h08);
    `CHK(near(tb, ticks(400, 10)), 1'b1)
    @(posedge mclk);
    sleep <= 1'b1;
    run(2);
    `CHK(xrun, 1'b1)
    $display("test crystal done");
    summarize();
  end
endmodule
